// *** fqt_pkg.sv ***
// constants and types for the flash query erase-region table
package fqt_pkg;
  localparam int FQT_ADDR_W = 9;
  localparam int FQT_DATA_W = 16;
  localparam int FQT_DESC_BYTES = 14;
  localparam logic [8:0] FQT_REGION_COUNT_ADDR = 9'h135;
  localparam logic [8:0] FQT_T1_GEOMETRY = 9'h136;
  localparam logic [8:0] FQT_T1_ENDURANCE = 9'h13a;
  localparam logic [8:0] FQT_T1_CELL_INFO = 9'h13c;
  localparam logic [8:0] FQT_T1_READ_CAPS = 9'h13d;
  localparam logic [8:0] FQT_T1_PROG_REGION = 9'h13e;
  localparam logic [8:0] FQT_T2_GEOMETRY = 9'h144;
  localparam logic [8:0] FQT_T2_ENDURANCE = 9'h148;
  localparam logic [8:0] FQT_T2_CELL_INFO = 9'h14a;
  localparam logic [8:0] FQT_T2_READ_CAPS = 9'h14b;
  localparam logic [8:0] FQT_T2_PROG_REGION = 9'h14c;
  localparam logic [8:0] FQT_T2_LAST = 9'h151;
  localparam logic [7:0] FQT_REGION_COUNT = 8'h02;
  localparam logic [15:0] FQT_ENDURANCE_K = 16'h0064;
  localparam logic [3:0] FQT_BITS_PER_CELL = 4'h2;
  localparam logic FQT_ECC_USED = 1'b0;
  localparam logic FQT_PAGE_RD_OK = 1'b1;
  localparam logic FQT_SYNC_RD_OK = 1'b1;
  localparam logic FQT_SYNC_WR_OK = 1'b0;
  localparam logic [7:0] FQT_PROG_EXP = 8'h00;
  localparam logic FQT_PROG_LEGACY = 1'b1;
  localparam logic [7:0] FQT_CTRL_VALID = 8'h00;
  localparam logic [7:0] FQT_CTRL_INVALID = 8'h00;
  localparam logic FQT_CTRL_LEGACY = 1'b1;
  localparam int FQT_SIZE_UNIT = 256;
  localparam int FQT_PARAM_BLKS = 4;
  localparam int FQT_PARAM_BLK_BYTES = 32768;
  localparam int FQT_MAIN_BLK_BYTES = 131072;
  localparam int FQT_MBIT_BYTES = 131072;
  localparam int FQT_CFG_SETTLE = 2;
  localparam logic [7:0] FQT_CMD_QUERY = 8'h98;
  localparam logic [7:0] FQT_CMD_READ_ARRAY = 8'hff;
  localparam logic [7:0] FQT_CMD_READ_STATUS = 8'h70;
  localparam logic [7:0] FQT_CMD_READ_ID = 8'h90;

  typedef enum logic [1:0] {
    FQT_DENS_64 = 2'b00,
    FQT_DENS_128 = 2'b01,
    FQT_DENS_256 = 2'b10
  } fqt_density_t;

  typedef enum logic {
    FQT_MODE_OTHER = 1'b0,
    FQT_MODE_QUERY = 1'b1
  } fqt_mode_t;

  typedef struct packed {
    logic [47:0] prog_region;
    logic [7:0] read_caps;
    logic [7:0] cell_info;
    logic [15:0] endurance;
    logic [31:0] geometry;
  } fqt_desc_t;

  typedef struct packed {
    logic ce_n;
    logic oe_n;
    logic we_n;
    logic [8:0] addr;
    logic [7:0] cmd;
    logic [1:0] density;
    logic top_cfg;
  } fqt_pins_t;
endpackage

// *** fqt_rom.sv ***
// constant descriptor table for the two erase-block types
`timescale 1ns/10ps
module fqt_rom
  import fqt_pkg::*;
(
  input wire logic [8:0] addr,
  input wire logic [1:0] density,
  input wire logic top_cfg,
  output logic [7:0] byte_o
);
  fqt_desc_t param_desc;
  fqt_desc_t main_desc;
  fqt_desc_t sel_desc;
  logic [15:0] main_y;
  logic [8:0] offs;

  // main block count minus one from density
  function automatic logic [15:0] main_count_m1(input logic [1:0] d);
    int mbit;
    unique case (d)
      FQT_DENS_64: mbit = 64;
      FQT_DENS_128: mbit = 128;
      default: mbit = 256;
    endcase
    return 16'((mbit * FQT_MBIT_BYTES - FQT_PARAM_BLKS * FQT_PARAM_BLK_BYTES)
               / FQT_MAIN_BLK_BYTES - 1);
  endfunction

  // common fields of one descriptor
  function automatic fqt_desc_t build(input logic [15:0] y, input logic [15:0] z);
    fqt_desc_t d;
    d.geometry = {z, y};
    d.endurance = FQT_ENDURANCE_K;
    d.cell_info = {3'h0, FQT_ECC_USED, FQT_BITS_PER_CELL};
    d.read_caps = {5'h00, FQT_SYNC_WR_OK, FQT_SYNC_RD_OK, FQT_PAGE_RD_OK};
    d.prog_region = {FQT_CTRL_LEGACY, 7'h00, FQT_CTRL_INVALID, 8'h00, FQT_CTRL_VALID,
                     FQT_PROG_LEGACY, 7'h00, FQT_PROG_EXP};
    return d;
  endfunction

  assign main_y = main_count_m1(density);
  assign param_desc = build(16'(FQT_PARAM_BLKS - 1), 16'(FQT_PARAM_BLK_BYTES / FQT_SIZE_UNIT));
  assign main_desc = build(main_y, 16'(FQT_MAIN_BLK_BYTES / FQT_SIZE_UNIT));

  // type 1 is the parameter group on bottom parts, the main group on top parts
  always_comb begin
    byte_o = 8'h00;
    offs = 9'h000;
    sel_desc = top_cfg ? main_desc : param_desc;
    if (addr == FQT_REGION_COUNT_ADDR) begin
      byte_o = FQT_REGION_COUNT;
    end else if (addr >= FQT_T1_GEOMETRY && addr < FQT_T2_GEOMETRY) begin
      offs = addr - FQT_T1_GEOMETRY;
      byte_o = sel_desc[8 * offs[3:0] +: 8];
    end else if (addr >= FQT_T2_GEOMETRY && addr <= FQT_T2_LAST) begin
      sel_desc = top_cfg ? param_desc : main_desc;
      offs = addr - FQT_T2_GEOMETRY;
      byte_o = sel_desc[8 * offs[3:0] +: 8];
    end
  end
endmodule

// *** fqt_query_table.sv ***
// query-space read path for the partition region 1 erase-block descriptors
`timescale 1ns/10ps
module fqt_query_table
  import fqt_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic ce_n,
  input wire logic oe_n,
  input wire logic we_n,
  input wire logic [8:0] addr,
  input wire logic [15:0] dq_i,
  input wire logic [1:0] density_sel,
  input wire logic top_cfg,
  output logic [15:0] dq_o,
  output logic dq_oe_n,
  output logic query_active
);
  fqt_pins_t pins_raw;
  fqt_pins_t sync1_q;
  fqt_pins_t sync2_q;
  logic we_n_d_q;
  logic wr_edge;
  logic rd_act;
  fqt_mode_t mode_q;
  logic [1:0] dens_q;
  logic top_q;
  logic cfg_done_q;
  logic [1:0] settle_q;
  logic [7:0] rom_byte;
  logic [15:0] dq_q;
  logic oe_n_q;

  assign pins_raw = '{ce_n: ce_n, oe_n: oe_n, we_n: we_n, addr: addr,
                      cmd: dq_i[7:0], density: density_sel, top_cfg: top_cfg};

  // two-flop synchroniser for every pin except dq_i[15:8], which is not used
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sync1_q <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, default: '0};
      sync2_q <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, default: '0};
    end else begin
      sync1_q <= pins_raw;
      sync2_q <= sync1_q;
    end
  end

  // write strobe rising edge latches a command
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      we_n_d_q <= 1'b1;
    end else begin
      we_n_d_q <= sync2_q.we_n;
    end
  end

  assign wr_edge = sync2_q.we_n & ~we_n_d_q & ~sync2_q.ce_n;
  assign rd_act = (mode_q == FQT_MODE_QUERY) & ~sync2_q.ce_n & ~sync2_q.oe_n & sync2_q.we_n;

  // read state held until another read command
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      mode_q <= FQT_MODE_OTHER;
    end else if (wr_edge) begin
      unique case (sync2_q.cmd)
        FQT_CMD_QUERY: mode_q <= FQT_MODE_QUERY;
        FQT_CMD_READ_ARRAY,
        FQT_CMD_READ_STATUS,
        FQT_CMD_READ_ID: mode_q <= FQT_MODE_OTHER;
        default: mode_q <= mode_q;
      endcase
    end
  end

  // straps caught once after reset, once the synchroniser has settled
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      settle_q <= 2'h0;
      cfg_done_q <= 1'b0;
      dens_q <= FQT_DENS_64;
      top_q <= 1'b0;
    end else if (!cfg_done_q) begin
      if (settle_q == 2'(FQT_CFG_SETTLE)) begin
        dens_q <= sync2_q.density;
        top_q <= sync2_q.top_cfg;
        cfg_done_q <= 1'b1;
      end else begin
        settle_q <= settle_q + 2'h1;
      end
    end
  end

  fqt_rom u_rom (
    .addr(sync2_q.addr),
    .density(dens_q),
    .top_cfg(top_q),
    .byte_o(rom_byte)
  );

  // data and enable registered; upper lines held low
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      dq_q <= 16'h0000;
      oe_n_q <= 1'b1;
    end else begin
      oe_n_q <= ~rd_act;
      if (rd_act) begin
        dq_q <= {8'h00, rom_byte};
      end else begin
        dq_q <= 16'h0000;
      end
    end
  end

  assign dq_o = dq_q;
  assign dq_oe_n = oe_n_q;
  assign query_active = (mode_q == FQT_MODE_QUERY);

  // checks
  sequence rd_at(logic [8:0] a);
    rd_act && sync2_q.addr == a;
  endsequence

  sequence cmd_wr(logic [7:0] c);
    wr_edge && sync2_q.cmd == c;
  endsequence

  sequence pin_read;
    sync2_q.ce_n == 1'b0 && sync2_q.oe_n == 1'b0 && sync2_q.we_n && query_active;
  endsequence

  property byte_after(logic [8:0] a, logic [7:0] v);
    @(posedge clk_sys) disable iff (rst)
      rd_at(a) |=> dq_o == {8'h00, v};
  endproperty

  default clocking cb @(posedge clk_sys);
  endclocking

  default disable iff (rst);

  geom_count_a: assert property (
    rd_at(FQT_T1_GEOMETRY) ##0 !top_q
      |=> dq_o[7:0] == 8'(FQT_PARAM_BLKS - 1))
    else $error("type 1 block count byte wrong");

  main_count_a: assert property (
    rd_at(FQT_T2_GEOMETRY) ##0 (!top_q && dens_q == FQT_DENS_128)
      |=> dq_o[7:0] == 8'h7e)
    else $error("main block count byte wrong");

  geom_size_a: assert property (
    rd_at(9'h138) ##0 !top_q |=> dq_o[7:0] == 8'(FQT_PARAM_BLK_BYTES / FQT_SIZE_UNIT))
    else $error("type 1 block size byte wrong");

  main_size_a: assert property (
    rd_at(9'h147) ##0 !top_q |=> dq_o[7:0] == 8'h02)
    else $error("main block size high byte wrong");

  endurance_low_a: assert property (byte_after(FQT_T2_ENDURANCE, FQT_ENDURANCE_K[7:0]))
    else $error("endurance low byte wrong");

  endurance_high_a: assert property (
    rd_at(9'h13b) |=> dq_o == {8'h00, FQT_ENDURANCE_K[15:8]})
    else $error("endurance high byte wrong");

  cell_bits_a: assert property (
    rd_at(FQT_T1_CELL_INFO) |=> dq_o[3:0] == FQT_BITS_PER_CELL && dq_o[7:5] == 3'h0)
    else $error("bits per cell field wrong");

  ecc_flag_a: assert property (
    rd_at(FQT_T2_CELL_INFO) |=> dq_o[4] == FQT_ECC_USED)
    else $error("error correction flag wrong");

  read_caps_a: assert property (
    rd_at(FQT_T1_READ_CAPS) or rd_at(FQT_T2_READ_CAPS)
      |=> dq_o[0] == FQT_PAGE_RD_OK && dq_o[1] == FQT_SYNC_RD_OK
          && dq_o[2] == FQT_SYNC_WR_OK && dq_o[7:3] == 5'h00)
    else $error("capability byte wrong");

  prog_exp_a: assert property (byte_after(FQT_T1_PROG_REGION, FQT_PROG_EXP))
    else $error("region exponent wrong");

  prog_legacy_a: assert property (
    rd_at(9'h14d) |=> dq_o[7] == FQT_PROG_LEGACY && dq_o[6:0] == 7'h00)
    else $error("region legacy flag wrong");

  ctrl_valid_a: assert property (
    rd_at(9'h140) |=> dq_o == {8'h00, FQT_CTRL_VALID})
    else $error("valid size byte wrong");
  rsvd_mid_a: assert property (byte_after(9'h141, 8'h00))
    else $error("reserved byte not zero");

  ctrl_valid_byte_a: assert property (byte_after(9'h14e, FQT_CTRL_VALID))
    else $error("valid size byte wrong");

  rsvd_hi_a: assert property (byte_after(9'h14f, 8'h00))
    else $error("reserved byte not zero");

  ctrl_invalid_a: assert property (byte_after(9'h150, FQT_CTRL_INVALID))
    else $error("invalid size byte wrong");

  ctrl_legacy_a: assert property (
    rd_at(9'h143) |=> dq_o[7] == FQT_CTRL_LEGACY && dq_o[6:0] == 7'h00)
    else $error("control legacy byte wrong");

  group_edge_a: assert property (
    rd_act && (sync2_q.addr > FQT_T2_LAST || sync2_q.addr < FQT_REGION_COUNT_ADDR)
      |=> dq_o == 16'h0000)
    else $error("unmapped query address not zero");

  region_count_a: assert property (byte_after(FQT_REGION_COUNT_ADDR, FQT_REGION_COUNT))
    else $error("region count wrong");

  query_entry_a: assert property (
    cmd_wr(FQT_CMD_QUERY) |=> query_active)
    else $error("query command not taken");

  query_exit_a: assert property (
    cmd_wr(FQT_CMD_READ_ARRAY) or cmd_wr(FQT_CMD_READ_STATUS) or cmd_wr(FQT_CMD_READ_ID)
      |=> !query_active)
    else $error("read command did not leave query");

  query_hold_a: assert property (
    query_active && !wr_edge |=> query_active)
    else $error("query state lost without command");

  pin_to_data_a: assert property (
    pin_read ##1 (rd_act && !wr_edge) |=> !dq_oe_n)
    else $error("query read not driven");

  upper_zero_a: assert property (
    !dq_oe_n |-> dq_o[15:8] == 8'h00)
    else $error("upper data lines not zero");

  release_a: assert property (
    !rd_act |=> dq_oe_n && dq_o == 16'h0000)
    else $error("bus not released");

  fixed_data_a: assert property (
    rd_act ##1 (rd_act && $stable(sync2_q.addr) && cfg_done_q && $past(cfg_done_q))
      |=> $stable(dq_o))
    else $error("table byte changed");

  cfg_once_a: assert property (
    cfg_done_q |=> $stable(dens_q) && $stable(top_q))
    else $error("configuration changed after capture");
endmodule

// *** fqt_host_model.sv ***
// host controller model driving the flash query pins
`timescale 1ns/10ps
module fqt_host_model
  import fqt_pkg::*;
(
  input wire logic clk_sys,
  input wire logic [15:0] dq_o,
  input wire logic dq_oe_n,
  output logic ce_n,
  output logic oe_n,
  output logic we_n,
  output logic [8:0] addr,
  output logic [15:0] dq_i,
  output logic rd_done,
  output logic [16:0] rd_data
);
  initial begin
    ce_n = 1'b1;
    oe_n = 1'b1;
    we_n = 1'b1;
    addr = 9'h000;
    dq_i = 16'h0000;
    rd_done = 1'b0;
    rd_data = 17'h00000;
  end

  task automatic hold(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  // command write, data held around the we_n rise
  task automatic cmd(input logic [7:0] c, input logic [7:0] hi);
    ce_n = 1'b0;
    dq_i = {hi, c};
    hold(3);
    we_n = 1'b0;
    hold(3);
    we_n = 1'b1;
    hold(3);
    ce_n = 1'b1;
    dq_i = ~dq_i;
    hold(3);
  endtask

  // query read, result handed on with a one-cycle strobe
  task automatic rd(input logic [8:0] a);
    ce_n = 1'b0;
    oe_n = 1'b0;
    addr = a;
    hold(4);
    rd_data = {dq_oe_n, dq_o};
    rd_done = 1'b1;
    hold(1);
    rd_done = 1'b0;
    oe_n = 1'b1;
    ce_n = 1'b1;
    addr = ~a;
    hold(4);
  endtask
endmodule

// *** tb_fqt_query_table.sv ***
// self-checking bench for the query table read path
`timescale 1ns/10ps
module tb_fqt_query_table;
  import fqt_pkg::*;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic [1:0] density_sel = 2'b00;
  logic top_cfg = 1'b0;
  logic ce_n, oe_n, we_n, rd_done, dq_oe_n, query_active;
  logic [8:0] addr;
  logic [15:0] dq_i, dq_o;
  logic [16:0] rd_data;
  logic [17:0] exp_q[$];
  logic [7:0] leave_cmd [3] = '{8'hff, 8'h70, 8'h90};
  int fails = 0;
  int n_checks = 0;

  always #5 clk_sys = ~clk_sys;

  fqt_query_table i_dut (.clk_sys(clk_sys), .rst(rst), .ce_n(ce_n), .oe_n(oe_n),
    .we_n(we_n), .addr(addr), .dq_i(dq_i), .density_sel(density_sel),
    .top_cfg(top_cfg), .dq_o(dq_o), .dq_oe_n(dq_oe_n), .query_active(query_active));

  fqt_host_model i_host (.clk_sys(clk_sys), .dq_o(dq_o), .dq_oe_n(dq_oe_n),
    .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .addr(addr), .dq_i(dq_i),
    .rd_done(rd_done), .rd_data(rd_data));

  // expected table byte, built from field meanings
  function automatic logic [7:0] exp_b(logic [8:0] a, logic [1:0] ds, logic top);
    logic [31:0] gp, gm;
    logic [79:0] tail;
    logic [111:0] g1, g2;
    int d;
    d = (ds == 2'b11) ? 2 : int'(ds);
    gp = {16'(32768 / 256), 16'(4 - 1)};
    gm = {16'(131072 / 256), 16'((64 << d) - 2)};
    tail = {48'h8000_0000_8000,
            8'h03, 8'h02,
            16'(100000 / 1000)};
    g1 = top ? {tail, gm} : {tail, gp};
    g2 = top ? {tail, gp} : {tail, gm};
    if (a == 9'h135) return 8'h02;
    if (a >= 9'h136 && a <= 9'h143) return 8'(g1 >> (8 * (a - 9'h136)));
    if (a >= 9'h144 && a <= 9'h151) return 8'(g2 >> (8 * (a - 9'h144)));
    return 8'h00;
  endfunction

  task automatic chk(input logic [17:0] seen, input logic [17:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // note expectation, then read through the host model
  task automatic rd_exp(input logic [8:0] a, input logic q);
    exp_q.push_back(q ? {2'b10, 8'h00, exp_b(a, density_sel, top_cfg)} : {2'b01, 16'h0000});
    i_host.rd(a);
  endtask

  task automatic print_verdict();
    if (fails == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // result monitor
  always @(negedge clk_sys) begin
    if (rd_done) begin
      chk({query_active, rd_data}, exp_q.pop_front());
    end
  end

  initial begin
    logic [7:0] junk;
    void'($urandom(38));
    for (int s = 0; s < 8; s++) begin
      rst = 1'b1;
      density_sel = s[1:0];
      top_cfg = s[2];
      repeat (6) @(posedge clk_sys);
      #1;
      rst = 1'b0;
      repeat (6) @(posedge clk_sys);
      #1;
      rd_exp(9'h136, 1'b0);
      i_host.cmd(8'h98, 8'($urandom));
      for (int a = 'h134; a <= 'h152; a++) begin
        rd_exp(9'(a), 1'b1);
      end
      rd_exp(9'($urandom), 1'b1);
      do begin
        junk = 8'($urandom);
      end while (junk inside {8'h98, 8'hff, 8'h70, 8'h90});
      i_host.cmd(junk, 8'($urandom));
      rd_exp(9'h135 + 9'($urandom_range(28)), 1'b1);
      rd_exp(9'h144, 1'b1);
      i_host.cmd(leave_cmd[s % 3], 8'h00);
      rd_exp(9'h13a, 1'b0);
      i_host.cmd(8'h98, 8'h00);
      rd_exp(9'h151, 1'b1);
    end
    print_verdict();
  end

  // watchdog
  initial begin
    #(50000 * 10);
    fails++;
    $display("[ERR] %0t watchdog expired", $time);
    print_verdict();
  end
endmodule
